/* File: verilog/srx_status_irq.sv */
// Receiver status, interrupt mask and cause registers, and error fill
// for the receiver-to-DAC and receiver-to-transmitter data paths.
// Assumes the receiver core and the serial control interface both run
// on mclk_in and present single-cycle register strobes.
`timescale 1ns/10ps

module srx_status_irq
  import srx_pkg::*;
(
  input  wire logic                   mclk_in,
  input  wire logic                   rst_in,
  input  wire srx_flags_t             flags_in,
  input  wire logic                   frame_valid_in,
  input  wire srx_frame_t             frame_in,
  input  wire logic [`SRX_ADDR_W-1:0] reg_addr_in,
  input  wire logic                   reg_wr_in,
  input  wire logic                   reg_rd_in,
  input  wire logic [`SRX_REG_W-1:0]  reg_wdata_in,
  output logic [`SRX_REG_W-1:0]       reg_rdata_out,
  output logic                        reg_rvalid_out,
  output logic                        irq_low_out,
  output srx_frame_t                  dac_frame_out,
  output logic                        dac_frame_valid_out,
  output srx_frame_t                  tx_frame_out,
  output logic                        tx_frame_valid_out
);

  srx_irq_state_t s_r;
  srx_irq_state_t s_nxt;

  logic       ignore_validity;
  logic       corrupt_fill_select;
  logic       valid_eff;
  logic [6:0] status_now;
  logic [8:0] event_raw;
  logic [8:0] event_on;
  logic [7:0] cause_set;
  logic [7:0] cause_keep;
  logic       cause_read;
  logic       dac_corrupt;
  logic       tx_corrupt;

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  function automatic logic [`SRX_REG_W-1:0] read_mux(
    input logic [`SRX_ADDR_W-1:0] addr,
    input srx_irq_state_t         st
  );
    logic [`SRX_REG_W-1:0] v;
    v = '0;
    case (addr)
      `SRX_OFF_MASK:    v = st.mask;
      `SRX_OFF_GPO_ONE: v = st.gpo_one;
      `SRX_OFF_GPO_TWO: v = st.gpo_two;
      `SRX_OFF_CAUSE:   v = {1'b0, st.cause};
      `SRX_OFF_STATUS:  v = {2'b00, st.status};
      default:          v = '0;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Control bits and current flag picture
  // ----------------------------------------------------------------
  // validity use or ignore
  assign ignore_validity     = s_r.gpo_two[`SRX_BIT_IGNVAL];
  assign corrupt_fill_select = s_r.gpo_one[`SRX_BIT_FILL];
  assign valid_eff = flags_in.validity_error & ~ignore_validity;

  always_comb begin
    status_now[0]   = flags_in.non_pcm;
    status_now[1]   = flags_in.burst_sync;
    status_now[2]   = flags_in.copyright_low;
    status_now[3]   = flags_in.preemphasis_flag;
    status_now[5:4] = flags_in.recovered_rate;
    status_now[6]   = flags_in.unlock;
  end

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  always_comb begin
    event_raw = '0;
    if (s_r.primed) begin
      event_raw[`SRX_EV_LOCK]    = status_now[6] ^ s_r.status[6];
      event_raw[`SRX_EV_NONPCM]  = status_now[0] ^ s_r.status[0];
      event_raw[`SRX_EV_BURST]   = status_now[1] ^ s_r.status[1];
      event_raw[`SRX_EV_COPY]    = status_now[2] ^ s_r.status[2];
      event_raw[`SRX_EV_PREEMPH] = status_now[3] ^ s_r.status[3];
      event_raw[`SRX_EV_RATE]    = |(status_now[5:4] ^ s_r.status[5:4]);
      event_raw[`SRX_EV_VALID] = valid_eff & ~s_r.prev_valid;
      event_raw[`SRX_EV_TRANS] = flags_in.transport_error
                                 & ~s_r.prev_trans;
      event_raw[`SRX_EV_CHAN_STATUS_UPDATED]  = flags_in.chan_status_updated
                                 & ~s_r.prev_chan_status_updated;
    end
  end

  assign event_on = event_raw & ~s_r.mask;

  always_comb begin
    cause_set                   = '0;
    cause_set[`SRX_CA_LOCK]     = event_on[`SRX_EV_LOCK];
    cause_set[`SRX_CA_VALID]    = event_on[`SRX_EV_VALID];
    cause_set[`SRX_CA_CHAN_STATUS_UPDATED]     = event_on[`SRX_EV_CHAN_STATUS_UPDATED];
    cause_set[`SRX_CA_TRANS]    = event_on[`SRX_EV_TRANS];
    cause_set[`SRX_CA_NONAUDIO] = event_on[`SRX_EV_NONPCM]
                                  | event_on[`SRX_EV_BURST];
    cause_set[`SRX_CA_COPY]     = event_on[`SRX_EV_COPY];
    cause_set[`SRX_CA_PREEMPH]  = event_on[`SRX_EV_PREEMPH];
    cause_set[`SRX_CA_RATE]     = event_on[`SRX_EV_RATE];
  end

  // ----------------------------------------------------------------
  // Read-to-clear with persistence of active level flags
  // ----------------------------------------------------------------
  assign cause_read = reg_rd_in && (reg_addr_in == `SRX_OFF_CAUSE);

  always_comb begin
    cause_keep = '0;
    cause_keep[`SRX_CA_VALID] = valid_eff & ~s_r.mask[`SRX_EV_VALID];
    cause_keep[`SRX_CA_TRANS] = flags_in.transport_error
                                & ~s_r.mask[`SRX_EV_TRANS];
    cause_keep[`SRX_CA_CHAN_STATUS_UPDATED]  = flags_in.chan_status_updated
                                & ~s_r.mask[`SRX_EV_CHAN_STATUS_UPDATED];
    cause_keep = cause_keep & s_r.cause;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;

    s_nxt.status     = status_now;
    s_nxt.prev_valid = valid_eff;
    s_nxt.prev_trans = flags_in.transport_error;
    s_nxt.prev_chan_status_updated  = flags_in.chan_status_updated;
    s_nxt.primed     = 1'b1;

    if (cause_read) begin
      s_nxt.cause = cause_keep | cause_set;
    end else begin
      s_nxt.cause = s_r.cause | cause_set;
    end

    if (reg_wr_in) begin
      case (reg_addr_in)
        `SRX_OFF_MASK:    s_nxt.mask    = reg_wdata_in;
        `SRX_OFF_GPO_ONE: s_nxt.gpo_one = reg_wdata_in;
        `SRX_OFF_GPO_TWO: s_nxt.gpo_two = reg_wdata_in;
        default:          s_nxt.mask    = s_r.mask;
      endcase
    end

    s_nxt.rvalid = reg_rd_in;
    if (reg_rd_in) begin
      s_nxt.rdata = read_mux(reg_addr_in, s_r);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s_r         <= '0;
      s_r.mask    <= `SRX_RST_MASK;
      s_r.gpo_one <= `SRX_RST_GPO_ONE;
      s_r.gpo_two <= `SRX_RST_GPO_TWO;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata_out  = s_r.rdata;
  assign reg_rvalid_out = s_r.rvalid;
  assign irq_low_out    = ~|s_r.cause;

  // ----------------------------------------------------------------
  // Error fill
  // ----------------------------------------------------------------
  // mask bits pick errors
  assign dac_corrupt =
    (valid_eff & s_r.mask[`SRX_EV_VALID])
    | (flags_in.transport_error & s_r.mask[`SRX_EV_TRANS]);
  assign tx_corrupt = valid_eff & s_r.mask[`SRX_EV_VALID];

  srx_frame_fill u_dac_fill (
    .mclk_in         (mclk_in),
    .rst_in          (rst_in),
    .frame_valid_in  (frame_valid_in),
    .frame_in        (frame_in),
    .corrupt_in      (dac_corrupt),
    .zero_fill_in    (corrupt_fill_select),
    .frame_out       (dac_frame_out),
    .frame_valid_out (dac_frame_valid_out)
  );

  srx_frame_fill u_tx_fill (
    .mclk_in         (mclk_in),
    .rst_in          (rst_in),
    .frame_valid_in  (frame_valid_in),
    .frame_in        (frame_in),
    .corrupt_in      (tx_corrupt),
    .zero_fill_in    (corrupt_fill_select),
    .frame_out       (tx_frame_out),
    .frame_valid_out (tx_frame_valid_out)
  );

endmodule

/* File: verilog/srx_map.svh */
// Register map, field positions and reset values of the receiver
// status and interrupt block. Definitions only.
`ifndef SRX_MAP_SVH
`define SRX_MAP_SVH

// ----------------------------------------------------------------
// Register port geometry and sample width
// ----------------------------------------------------------------
`define SRX_ADDR_W        7
`define SRX_REG_W         9
`define SRX_SAMPLE_W      24

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SRX_OFF_MASK      7'h25
`define SRX_OFF_GPO_ONE   7'h26
`define SRX_OFF_GPO_TWO   7'h27
`define SRX_OFF_CAUSE     7'h2B
`define SRX_OFF_STATUS    7'h31

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SRX_RST_MASK      9'h000
`define SRX_RST_GPO_ONE   9'h010
`define SRX_RST_GPO_TWO   9'h032

// ----------------------------------------------------------------
// Mask register bits (event index)
// ----------------------------------------------------------------
`define SRX_EV_LOCK       0
`define SRX_EV_VALID      1
`define SRX_EV_CHAN_STATUS_UPDATED       2
`define SRX_EV_TRANS      3
`define SRX_EV_NONPCM     4
`define SRX_EV_BURST      5
`define SRX_EV_COPY       6
`define SRX_EV_PREEMPH    7
`define SRX_EV_RATE       8

// ----------------------------------------------------------------
// Cause register bits
// ----------------------------------------------------------------
`define SRX_CA_LOCK       0
`define SRX_CA_VALID      1
`define SRX_CA_CHAN_STATUS_UPDATED       2
`define SRX_CA_TRANS      3
`define SRX_CA_NONAUDIO   4
`define SRX_CA_COPY       5
`define SRX_CA_PREEMPH    6
`define SRX_CA_RATE       7

// ----------------------------------------------------------------
// Control bits in the output select registers
// ----------------------------------------------------------------
`define SRX_BIT_FILL      8
`define SRX_BIT_IGNVAL    8

`endif

/* File: verilog/srx_pkg.sv */
// Types shared by the receiver status and interrupt block.
// Assumes srx_map.svh is on the include path.
`include "srx_map.svh"

package srx_pkg;

  // ----------------------------------------------------------------
  // Flags from the receiver core
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       non_pcm;
    logic       burst_sync;
    logic       copyright_low;
    logic       preemphasis_flag;
    logic [1:0] recovered_rate;
    logic       unlock;
    logic       validity_error;
    logic       transport_error;
    logic       chan_status_updated;
  } srx_flags_t;

  // ----------------------------------------------------------------
  // One recovered frame, both sub-frames
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`SRX_SAMPLE_W-1:0] left;
    logic [`SRX_SAMPLE_W-1:0] right;
  } srx_frame_t;

  typedef struct packed {
    srx_frame_t held;
    srx_frame_t out;
    logic       valid;
  } srx_fill_state_t;

  typedef struct packed {
    logic [`SRX_REG_W-1:0] mask;
    logic [`SRX_REG_W-1:0] gpo_one;
    logic [`SRX_REG_W-1:0] gpo_two;
    logic [7:0]            cause;
    logic [6:0]            status;
    logic                  prev_valid;
    logic                  prev_trans;
    logic                  prev_chan_status_updated;
    logic                  primed;
    logic [`SRX_REG_W-1:0] rdata;
    logic                  rvalid;
  } srx_irq_state_t;

endpackage

/* File: verilog/srx_frame_fill.sv */
// Corrupt-frame replacement for one data path.
// Assumes frames and the corrupt flag arrive on the same clock.
`timescale 1ns/10ps

module srx_frame_fill
  import srx_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  input  wire logic       frame_valid_in,
  input  wire srx_frame_t frame_in,
  input  wire logic       corrupt_in,
  input  wire logic       zero_fill_in,
  output srx_frame_t      frame_out,
  output logic            frame_valid_out
);

  srx_fill_state_t s_r;
  srx_fill_state_t s_nxt;

  // ----------------------------------------------------------------
  // Replace corrupt frames, remember good ones
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt       = s_r;
    s_nxt.valid = frame_valid_in;
    if (frame_valid_in) begin
      if (!corrupt_in) begin
        s_nxt.held = frame_in;
        s_nxt.out  = frame_in;
      end else if (zero_fill_in) begin
        s_nxt.out = '0;
      end else begin
        s_nxt.out = s_r.held;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign frame_out       = s_r.out;
  assign frame_valid_out = s_r.valid;

endmodule

/* File: tb/srx_status_irq_chk.sv */
// Assertions on the ports of the status and interrupt block.
// Assumes srx_pkg is compiled first; bound to every instance below.
`timescale 1ns/10ps
`include "srx_map.svh"

module srx_status_irq_chk
  import srx_pkg::*;
(
  input wire logic       mclk_in,
  input wire logic       rst_in,
  input wire srx_flags_t flags_in,
  input wire logic       frame_valid_in,
  input wire srx_frame_t frame_in,
  input wire logic [6:0] reg_addr_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [8:0] reg_wdata_in,
  input wire logic [8:0] reg_rdata_out,
  input wire logic       reg_rvalid_out,
  input wire logic       irq_low_out,
  input wire srx_frame_t dac_frame_out,
  input wire logic       dac_frame_valid_out,
  input wire srx_frame_t tx_frame_out,
  input wire logic       tx_frame_valid_out
);
  logic [8:0] msk_r;
  logic       fil_r;
  logic       ign_r;
  logic [1:0] up_r;
  logic       vb;
  logic       dbad;
  logic       tbad;
  logic [6:0] stv;
  logic       crd;

  // Shadow of the control bits the checks depend on
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      msk_r <= 9'h000;
      fil_r <= 1'b0;
      ign_r <= 1'b0;
      up_r  <= 2'h0;
    end else begin
      if (reg_wr_in && reg_addr_in == `SRX_OFF_MASK) begin
        msk_r <= reg_wdata_in;
      end
      if (reg_wr_in && reg_addr_in == `SRX_OFF_GPO_ONE) begin
        fil_r <= reg_wdata_in[8];
      end
      if (reg_wr_in && reg_addr_in == `SRX_OFF_GPO_TWO) begin
        ign_r <= reg_wdata_in[8];
      end
      if (up_r != 2'h3) begin
        up_r <= up_r + 2'h1;
      end
    end
  end

  assign vb   = flags_in.validity_error & ~ign_r;
  assign dbad = (vb & msk_r[1]) | (flags_in.transport_error & msk_r[3]);
  assign tbad = vb & msk_r[1];
  assign crd  = reg_rd_in && reg_addr_in == `SRX_OFF_CAUSE;
  assign stv  = {flags_in.unlock, flags_in.recovered_rate,
                 flags_in.preemphasis_flag, flags_in.copyright_low,
                 flags_in.burst_sync, flags_in.non_pcm};

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  a_status_fields: assert property (
    reg_rd_in && reg_addr_in == `SRX_OFF_STATUS && up_r == 2'h3 |=>
    reg_rdata_out == {2'h0, $past(stv, 2)})
    else $error("status read differs from flags");
  a_mask_read: assert property (
    reg_rd_in && reg_addr_in == `SRX_OFF_MASK |=>
    reg_rdata_out == $past(msk_r))
    else $error("mask read differs");
  a_lock_event: assert property (
    up_r == 2'h3 && $changed(flags_in.unlock) && !msk_r[0] |=> !irq_low_out)
    else $error("lock change gave no interrupt");
  a_masked_quiet: assert property (
    msk_r == 9'h1FF && irq_low_out |=> irq_low_out)
    else $error("interrupt while all masked");
  a_valid_event: assert property (
    up_r == 2'h3 && $rose(flags_in.validity_error) && !msk_r[1] && !ign_r
    |=> !irq_low_out)
    else $error("validity rise gave no interrupt");
  a_irq_sticky: assert property (
    !irq_low_out && !crd |=> !irq_low_out)
    else $error("interrupt dropped without cause read");
  a_level_persist: assert property (
    crd && flags_in.validity_error && !msk_r[1] && !ign_r && up_r == 2'h3
    |=> !irq_low_out)
    else $error("interrupt cleared while validity active");
  a_dac_pass: assert property (
    frame_valid_in && !dbad |=>
    dac_frame_valid_out && dac_frame_out == $past(frame_in))
    else $error("dac frame not passed");
  a_dac_zero: assert property (
    frame_valid_in && dbad && fil_r |=> dac_frame_out == '0)
    else $error("dac frame not zero filled");
  a_tx_path: assert property (
    frame_valid_in && !tbad |=>
    tx_frame_valid_out && tx_frame_out == $past(frame_in))
    else $error("tx frame not passed");

  c_zero_fill: cover property (frame_valid_in && dbad && fil_r);
  c_persist: cover property (crd && flags_in.validity_error);
  c_lock: cover property ($changed(flags_in.unlock) && !msk_r[0]);
endmodule

bind srx_status_irq srx_status_irq_chk chk_u (
  .mclk_in(mclk_in), .rst_in(rst_in), .flags_in(flags_in),
  .frame_valid_in(frame_valid_in), .frame_in(frame_in),
  .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
  .irq_low_out(irq_low_out), .dac_frame_out(dac_frame_out),
  .dac_frame_valid_out(dac_frame_valid_out),
  .tx_frame_out(tx_frame_out), .tx_frame_valid_out(tx_frame_valid_out));

/* File: tb/srx_host.sv */
// Host model of the control side: register writes and reads.
// Assumes a read answers right after the edge that takes it.
`timescale 1ns/10ps

module srx_host (
  input  wire logic       mclk_in,
  input  wire logic [8:0] rdata_in,
  input  wire logic       rvalid_in,
  output logic [6:0]      addr_out,
  output logic            wr_out,
  output logic            rd_out,
  output logic [8:0]      wdata_out
);
  initial begin
    addr_out = 7'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 9'h000;
  end

  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    @(posedge mclk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge mclk_in);
    wr_out <= 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, output logic [8:0] d,
                    output logic ok);
    @(posedge mclk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge mclk_in);
    rd_out <= 1'b0;
    // Answer stands between the taking edge and the next one
    @(negedge mclk_in);
    ok = rvalid_in;
    d = rdata_in;
  endtask

  task automatic cfg_valid(input logic ign);
    wr(7'h27, {ign, 8'h32});
  endtask
endmodule

/* File: tb/srx_status_irq_tb_top.sv */
// Self-checking bench for the status and interrupt block.
// Assumes srx_host drives the register port in the host's place.
`timescale 1ns/10ps
`include "srx_map.svh"

module srx_status_irq_tb_top;
  import srx_pkg::*;
  logic       mclk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic       fv = 1'b0;
  srx_flags_t fl = '0;
  srx_frame_t fr = '0;
  logic [6:0] ad;
  logic       wr;
  logic       rd;
  logic [8:0] wd;
  logic [8:0] rdat;
  logic       rv;
  logic       irq;
  srx_frame_t dac;
  srx_frame_t tx;
  logic       dv;
  logic       tv;
  int         fail_count = 0;
  int         n_compared = 0;
  int         i;
  int         j;
  logic [8:0] mk;
  byte        fb[6] = '{9, 8, 7, 6, 4, 3};
  byte        mb[6] = '{4, 5, 6, 7, 8, 0};
  byte        cb[6] = '{4, 4, 5, 6, 7, 0};
  logic [8:0] ce[3] = '{9'h002, 9'h008, 9'h004};

  initial forever #4 mclk_in = ~mclk_in;

  srx_host host_u (.mclk_in(mclk_in), .rdata_in(rdat), .rvalid_in(rv),
    .addr_out(ad), .wr_out(wr), .rd_out(rd), .wdata_out(wd));

  srx_status_irq dut_u (.mclk_in(mclk_in), .rst_in(rst_in), .flags_in(fl),
    .frame_valid_in(fv), .frame_in(fr), .reg_addr_in(ad), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_wdata_in(wd), .reg_rdata_out(rdat),
    .reg_rvalid_out(rv), .irq_low_out(irq), .dac_frame_out(dac),
    .dac_frame_valid_out(dv), .tx_frame_out(tx), .tx_frame_valid_out(tv));

  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    n_compared++;
    if (g !== e) begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      fail_count++;
    end
  endtask

  task automatic rdc(input logic [6:0] a, input logic [8:0] e);
    logic [8:0] d;
    logic       ok;
    host_u.rd(a, d, ok);
    chk({47'h0, ok}, 48'h1);
    chk({39'h0, d}, {39'h0, e});
  endtask

  task automatic frame(input srx_frame_t f, input logic v, input logic t,
                       input srx_frame_t ed, input srx_frame_t et);
    @(posedge mclk_in);
    fv <= 1'b1;
    fr <= f;
    fl.validity_error <= v;
    fl.transport_error <= t;
    @(posedge mclk_in);
    fv <= 1'b0;
    fl.validity_error <= 1'b0;
    fl.transport_error <= 1'b0;
    // Valid pulses stand for one cycle only
    @(negedge mclk_in);
    chk({46'h0, dv, tv}, 48'h3);
    chk(dac, ed);
    chk(tx, et);
  endtask

  task final_report;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    final_report;
  end

  initial begin
    repeat (5) @(posedge mclk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    rdc(`SRX_OFF_MASK, 9'h000);
    rdc(`SRX_OFF_GPO_ONE, `SRX_RST_GPO_ONE);
    rdc(`SRX_OFF_GPO_TWO, `SRX_RST_GPO_TWO);
    rdc(`SRX_OFF_CAUSE, 9'h000);
    rdc(7'h10, 9'h000);
    host_u.wr(`SRX_OFF_MASK, 9'h1FF);
    rdc(`SRX_OFF_MASK, 9'h1FF);
    for (i = 0; i < 2; i++) begin
      @(posedge mclk_in);
      fl <= (i == 0) ? 10'h2A8 : 10'h150;
      repeat (3) @(posedge mclk_in);
      rdc(`SRX_OFF_STATUS, (i == 0) ? 9'h065 : 9'h01A);
      chk({47'h0, irq}, 48'h1);
    end
    rdc(`SRX_OFF_CAUSE, 9'h000);
    for (i = 0; i < 12; i++) begin
      j = i % 6;
      mk = 9'h001 << mb[j];
      host_u.wr(`SRX_OFF_MASK, (i < 6) ? mk : ~mk);
      @(posedge mclk_in);
      fl[fb[j]] <= ~fl[fb[j]];
      repeat (2) @(posedge mclk_in);
      chk({47'h0, irq}, (i < 6) ? 48'h1 : 48'h0);
      rdc(`SRX_OFF_CAUSE, (i < 6) ? 9'h000 : 9'h001 << cb[j]);
      chk({47'h0, irq}, 48'h1);
    end
    host_u.wr(`SRX_OFF_MASK, 9'h000);
    for (i = 0; i < 3; i++) begin
      @(posedge mclk_in);
      fl[2 - i] <= 1'b1;
      repeat (2) @(posedge mclk_in);
      rdc(`SRX_OFF_CAUSE, ce[i]);
      chk({47'h0, irq}, 48'h0);
      rdc(`SRX_OFF_CAUSE, ce[i]);
      @(posedge mclk_in);
      fl[2 - i] <= 1'b0;
      rdc(`SRX_OFF_CAUSE, ce[i]);
      repeat (2) @(posedge mclk_in);
      chk({47'h0, irq}, 48'h1);
    end
    host_u.cfg_valid(1'b1);
    @(posedge mclk_in);
    fl.validity_error <= 1'b1;
    repeat (2) @(posedge mclk_in);
    chk({47'h0, irq}, 48'h1);
    fl.validity_error <= 1'b0;
    host_u.cfg_valid(1'b0);
    frame(48'h123456ABCDEF, 0, 0, 48'h123456ABCDEF, 48'h123456ABCDEF);
    frame(48'hA5A5A55A5A5A, 1, 1, 48'hA5A5A55A5A5A, 48'hA5A5A55A5A5A);
    host_u.wr(`SRX_OFF_MASK, 9'h00A);
    frame(48'hFEDCBA654321, 0, 0, 48'hFEDCBA654321, 48'hFEDCBA654321);
    frame(48'h0F0F0FF0F0F0, 1, 0, 48'hFEDCBA654321, 48'hFEDCBA654321);
    frame(48'h0F0F0FF0F0F0, 0, 1, 48'hFEDCBA654321, 48'h0F0F0FF0F0F0);
    host_u.wr(`SRX_OFF_GPO_ONE, 9'h110);
    rdc(`SRX_OFF_GPO_ONE, 9'h110);
    frame(48'h0F0F0FF0F0F0, 1, 0, 48'h0, 48'h0);
    frame(48'h0F0F0FF0F0F0, 0, 1, 48'h0, 48'h0F0F0FF0F0F0);
    host_u.cfg_valid(1'b1);
    frame(48'h0F0F0FF0F0F0, 1, 0, 48'h0F0F0FF0F0F0, 48'h0F0F0FF0F0F0);
    host_u.cfg_valid(1'b0);
    repeat (4) @(posedge mclk_in);
    final_report;
  end
endmodule
